// ===== bench/can_ctrl_model.sv
// behavioural can protocol controller seen through txd and the rxd pin
`timescale 1ns/1ps
module can_ctrl_model (
    input wire clk,
    input wire dom_req,
    input wire short_high,
    input wire rxd,
    input wire rxd_oe,
    output reg txd,
    output reg rxd_pin_level
);
    initial txd = 1'b1;
    initial rxd_pin_level = 1'b1;
    always @(negedge clk)
        txd <= ~dom_req;
    // a released pin floats, so it flips each cycle instead of holding its last level
    always @(negedge clk)
        rxd_pin_level <= short_high ? 1'b1 : (rxd_oe ? rxd : ~rxd_pin_level);
endmodule

// ===== bench/can_phy_diag_properties.sv
// concurrent checks on the can wake and fault diagnostic block
`timescale 1ns/1ps
`include "can_phy_diag_map.vh"
module can_phy_diag_properties #(
    parameter DOM_CLAMP = 50
)(
    input wire clk,
    input wire rst,
    input wire txd,
    input wire diff_rx,
    input wire [1:0] mode,
    input wire drv_enable,
    input wire term_to_ground,
    input wire split_enable,
    input wire rxd_oe,
    input wire wake_flag,
    input wire int_pulse,
    input wire [2:0] bus_fault,
    input wire bus_fault_valid,
    input wire clamp_flag,
    input wire rxd_high_flag
);
    reg [15:0] dom_cnt;
    reg [3:0] fell_cnt;
    reg txd_q;
    // counts raw pins; the design sees them two syncs later, so bounds carry slack
    always @(posedge clk)
    begin
        txd_q <= txd;
        if (rst)
            dom_cnt <= 16'h0000;
        else if (!diff_rx)
            dom_cnt <= 16'h0000;
        else if (dom_cnt != 16'hffff)
            dom_cnt <= dom_cnt + 16'h0001;
        if (rst)
            fell_cnt <= 4'h0;
        else if (txd_q && !txd && fell_cnt != 4'hf)
            fell_cnt <= fell_cnt + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_SLEEP_OFF: assert property (mode == `MODE_SLEEP && $past(mode) == `MODE_SLEEP |->
        !drv_enable && term_to_ground && !split_enable) else $error("sleep outputs wrong");
    AST_RXONLY_OFF: assert property (mode == `MODE_RXONLY && $past(mode) == `MODE_RXONLY
        |-> !drv_enable) else $error("driver on in receive-only");
    AST_RXD_FAULT_MODE: assert property ($rose(rxd_high_flag) |-> ##[0:2] mode == `MODE_RXONLY)
        else $error("rxd fault did not force receive-only");
    AST_RXD_OE_OFF: assert property ($rose(rxd_high_flag) |-> ##[0:1] !rxd_oe)
        else $error("rxd driver still on after fault");
    AST_RXD_HELD: assert property (rxd_high_flag && $past(rxd_high_flag) |-> !drv_enable)
        else $error("driver on while rxd fault flagged");
    AST_INT_PULSE: assert property (int_pulse |-> ##[0:1] wake_flag ##1 !int_pulse)
        else $error("interrupt pulse not tied to wake flag");
    AST_WAKE_SLEEP: assert property ($rose(wake_flag) |-> $past(mode) == `MODE_SLEEP)
        else $error("wake flagged outside sleep");
    AST_CLAMP_MIN: assert property ($rose(clamp_flag) |-> dom_cnt >= DOM_CLAMP)
        else $error("clamp flag too early");
    AST_CLAMP_MAX: assert property (dom_cnt == DOM_CLAMP + 8 |-> clamp_flag)
        else $error("clamp flag missing");
    AST_FAULT_CONFIRM: assert property ($rose(bus_fault_valid) |->
        fell_cnt >= 5 && bus_fault != `FAULT_NONE) else $error("fault reported too soon");
    COV_WAKE: cover property ($rose(wake_flag));
    COV_CLAMP: cover property ($rose(clamp_flag));
    COV_RXD: cover property ($rose(rxd_high_flag));
    COV_FAULT: cover property ($rose(bus_fault_valid));
endmodule
bind can_phy_wake_and_fault_diag can_phy_diag_properties #(.DOM_CLAMP(DOM_CLAMP))
    can_phy_diag_properties_i (.clk(clk), .rst(rst), .txd(txd), .diff_rx(diff_rx),
    .mode(mode), .drv_enable(drv_enable), .term_to_ground(term_to_ground),
    .split_enable(split_enable), .rxd_oe(rxd_oe), .wake_flag(wake_flag),
    .int_pulse(int_pulse), .bus_fault(bus_fault), .bus_fault_valid(bus_fault_valid),
    .clamp_flag(clamp_flag), .rxd_high_flag(rxd_high_flag));

// ===== bench/can_phy_wake_and_fault_diag_bench.sv
// self-checking bench for the can wake and fault diagnostic block
`timescale 1ns/1ps
`include "can_phy_diag_map.vh"
module can_phy_wake_and_fault_diag_bench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg dom_req = 1'b0;
    reg short_high = 1'b0;
    reg diff_rx = 1'b0;
    reg bus_stuck = 1'b0;
    reg wake_rx = 1'b0;
    reg [5:0] cmp = 6'h30;
    reg [2:0] fault = 3'h0;
    reg [1:0] mode_req = 2'h1;
    reg mode_req_strobe = 1'b0;
    reg wake_enable = 1'b0;
    reg single_pulse_wake_select = 1'b0;
    reg device_low_power = 1'b1;
    reg flags_read = 1'b0;
    reg saw_int = 1'b0;
    reg saw_wake = 1'b0;
    wire txd, rxd_pin_level, rxd, rxd_oe, drv_dominant, drv_enable, bias_enable;
    wire term_to_ground, split_enable, wake_flag, int_pulse, device_wake;
    wire bus_fault_valid, clamp_flag, rxd_high_flag;
    wire [2:0] bus_fault;
    wire [1:0] mode;
    int bad_count = 0;
    int n_compared = 0;
    int f;
    always #4 clk = ~clk;
    // comparator bits {lg, hg, lb, hb, l5, h5}; groups not at fault show their clean pattern
    function [5:0] cmp_of(input [2:0] c, input d);
        case (c)
            3'h1: cmp_of = d ? 6'h10 : 6'h00;
            3'h2: cmp_of = 6'h00;
            3'h3: cmp_of = d ? 6'h1c : 6'h3c;
            3'h4: cmp_of = d ? 6'h14 : 6'h3c;
            3'h5: cmp_of = d ? 6'h13 : 6'h33;
            3'h6: cmp_of = d ? 6'h11 : 6'h33;
            default: cmp_of = d ? 6'h10 : 6'h30;
        endcase
    endfunction
    // the bus and the comparators answer the driver half a cycle later
    always @(negedge clk)
    begin
        diff_rx <= bus_stuck | (drv_enable & drv_dominant);
        cmp <= cmp_of(fault, drv_dominant);
        if (int_pulse === 1'b1)
            saw_int <= 1'b1;
        if (device_wake === 1'b1)
            saw_wake <= 1'b1;
    end
    can_ctrl_model can_ctrl_model_i (.clk(clk), .dom_req(dom_req), .short_high(short_high),
        .rxd(rxd), .rxd_oe(rxd_oe), .txd(txd), .rxd_pin_level(rxd_pin_level));
    can_phy_wake_and_fault_diag #(.DOM_CLAMP(50), .RXD_CHECK_EN(1))
        can_phy_wake_and_fault_diag_i (.clk(clk), .rst(rst), .txd(txd),
        .rxd_pin_level(rxd_pin_level), .diff_rx(diff_rx), .wake_rx(wake_rx),
        .low_line_ground_cmp(cmp[5]), .high_line_ground_cmp(cmp[4]),
        .low_line_battery_cmp(cmp[3]), .high_line_battery_cmp(cmp[2]),
        .low_line_five_volt_cmp(cmp[1]), .high_line_five_volt_cmp(cmp[0]),
        .mode_req(mode_req), .mode_req_strobe(mode_req_strobe), .wake_enable(wake_enable),
        .single_pulse_wake_select(single_pulse_wake_select),
        .device_low_power(device_low_power), .flags_read(flags_read), .rxd(rxd),
        .rxd_oe(rxd_oe), .drv_dominant(drv_dominant), .drv_enable(drv_enable),
        .bias_enable(bias_enable), .term_to_ground(term_to_ground),
        .split_enable(split_enable), .wake_flag(wake_flag), .int_pulse(int_pulse),
        .device_wake(device_wake), .bus_fault(bus_fault), .bus_fault_valid(bus_fault_valid),
        .clamp_flag(clamp_flag), .rxd_high_flag(rxd_high_flag), .mode(mode));
    task chk(input logic [2:0] got, input logic [2:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task req(input [1:0] m);
        mode_req = m;
        mode_req_strobe = 1'b1;
        cyc(1);
        mode_req_strobe = 1'b0;
        cyc(4);
    endtask
    task rd;
        flags_read = 1'b1;
        cyc(1);
        flags_read = 1'b0;
        cyc(2);
    endtask
    task pulse(input int n);
        wake_rx = 1'b1;
        cyc(n);
        wake_rx = 1'b0;
        cyc(60);
    endtask
    task drv(input int k);
        repeat (k)
        begin
            dom_req = 1'b1;
            cyc(10);
            dom_req = 1'b0;
            cyc(10);
        end
    endtask
    task restart;
        rst = 1'b1;
        fault = 3'h0;
        cyc(8);
        rst = 1'b0;
        cyc(4);
    endtask
    task sleep_arm(input s);
        req(`MODE_SLEEP);
        wake_enable = 1'b1;
        single_pulse_wake_select = s;
        rd;
        saw_int = 1'b0;
        saw_wake = 1'b0;
    endtask
    task final_report;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #480000;
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        final_report;
    end
    initial
    begin
        restart;
        dom_req = 1'b1;
        cyc(8);
        chk(rxd, 1'b0, "rxd not low on dominant");
        dom_req = 1'b0;
        cyc(8);
        chk(rxd, 1'b1, "rxd not high on recessive");
        chk(rxd_high_flag, 1'b0, "false rxd fault");
        $display("test loopback done");
        sleep_arm(1'b0);
        chk(drv_enable, 1'b0, "driver on in sleep");
        chk({term_to_ground, split_enable}, 3'h2, "sleep termination wrong");
        pulse(40);
        pulse(40);
        pulse(70);
        pulse(70);
        chk(wake_flag, 1'b0, "early wake");
        pulse(70);
        chk(wake_flag, 1'b1, "pattern wake missing");
        chk({saw_int, saw_wake}, 3'h3, "wake pulses missing");
        chk(mode, `MODE_TXRX, "not back in normal mode");
        chk({bias_enable, term_to_ground, split_enable}, 3'h5, "not rebiased");
        sleep_arm(1'b0);
        pulse(70);
        pulse(70);
        cyc(15000);
        pulse(70);
        chk(wake_flag, 1'b0, "wake across window");
        pulse(70);
        pulse(70);
        chk(wake_flag, 1'b1, "count not restarted");
        $display("test pattern wake done");
        sleep_arm(1'b1);
        pulse(100);
        chk(wake_flag, 1'b0, "short single pulse woke");
        pulse(270);
        chk(wake_flag, 1'b1, "single pulse wake missing");
        sleep_arm(1'b0);
        wake_enable = 1'b0;
        repeat (3) pulse(70);
        chk(wake_flag, 1'b0, "wake while disabled");
        req(`MODE_TXRX);
        wake_enable = 1'b1;
        repeat (3) pulse(70);
        chk(wake_flag, 1'b0, "wake outside sleep");
        $display("test single and disabled wake done");
        restart;
        bus_stuck = 1'b1;
        cyc(40);
        bus_stuck = 1'b0;
        cyc(4);
        chk(clamp_flag, 1'b0, "clamp too early");
        bus_stuck = 1'b1;
        cyc(60);
        chk(clamp_flag, 1'b1, "clamp missing");
        bus_stuck = 1'b0;
        $display("test clamp done");
        for (f = 1; f < 7; f++)
        begin
            restart;
            fault = f[2:0];
            drv(4);
            chk(bus_fault_valid, 1'b0, "fault reported early");
            drv(2);
            chk(bus_fault_valid, 1'b1, "fault not reported");
            chk(bus_fault, f[2:0], "fault class wrong");
        end
        $display("test bus faults done");
        restart;
        short_high = 1'b1;
        dom_req = 1'b1;
        cyc(10);
        dom_req = 1'b0;
        cyc(10);
        chk(rxd_high_flag, 1'b1, "rxd fault missed");
        chk(mode, `MODE_RXONLY, "not receive-only");
        chk(rxd_oe, 1'b0, "rxd driver still on");
        chk({drv_enable, drv_dominant}, 3'h0, "driver on after rxd fault");
        req(`MODE_TXRX);
        chk(mode, `MODE_RXONLY, "txrx taken with flag set");
        short_high = 1'b0;
        rd;
        req(`MODE_TXRX);
        cyc(4);
        chk(mode, `MODE_TXRX, "txrx refused after clear");
        chk(drv_enable, 1'b1, "driver not re-enabled");
        $display("test rxd fault done");
        final_report;
    end
endmodule

// ===== core/can_phy_diag_map.vh
// constants for the can transceiver wake and fault diagnostic logic
`ifndef CAN_PHY_DIAG_MAP_VH
`define CAN_PHY_DIAG_MAP_VH
`define CLK_PERIOD_PS 8000
`define WAKE_PULSE_MIN_NS 500
`define WAKE_SINGLE_PULSE_NS 2000
`define WAKE_WINDOW_US 120
`define DOM_CLAMP_TIMEOUT_US 1000
// least times round up, longest times round down
`define WAKE_PULSE_MIN_CYC ((`WAKE_PULSE_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAKE_SINGLE_CYC ((`WAKE_SINGLE_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAKE_WINDOW_CYC ((`WAKE_WINDOW_US * 1000000) / `CLK_PERIOD_PS)
`define DOM_CLAMP_CYC ((`DOM_CLAMP_TIMEOUT_US * 1000000) / `CLK_PERIOD_PS)
`define WAKE_PATTERN_PULSES 3
`define FAULT_CONFIRM_CYCLES 5
// fault classification codes
`define FAULT_NONE 3'h0
`define FAULT_LOW_GND 3'h1
`define FAULT_HIGH_GND 3'h2
`define FAULT_LOW_BAT 3'h3
`define FAULT_HIGH_BAT 3'h4
`define FAULT_LOW_5V 3'h5
`define FAULT_HIGH_5V 3'h6
`define FAULT_UNKNOWN 3'h7
// interface modes
`define MODE_SLEEP 2'h0
`define MODE_TXRX 2'h1
`define MODE_RXONLY 2'h2
`endif

// ===== core/can_phy_wake_and_fault_diag.v
// can transceiver sleep, wake-up and bus fault diagnostic control
// Overview of operation
// [R1] sleep: drivers off, lines to ground through input resistors, split high impedance
// [R2] bus wake sets a flag, pulses interrupt and wakes a low-power device
// [R3] return to normal from sleep rebiases lines to recessive
// [R4] wake detection only in sleep with enable set
// [R5] default: wake after three consecutive valid dominant pulses
// [R6] single pulse select: wake after one dominant pulse of about 2 us
// [R7] pattern pulses count only when longer than 500 ns
// [R8] three pattern pulses must fall within 120 us
// [R9] ground comparators decoded into line-to-ground shorts
// [R10] battery comparators decoded into line-to-battery shorts
// [R11] five volt comparators decoded into line-to-5V shorts
// [R12] line identified only after dominant-state comparator sample
// [R13] fault reported after same class seen five consecutive cycles
// [R14] dominant longer than clamp timeout sets bus failure flag
// [R15] rxd sampled on receiver rise; high means rxd stuck recessive
// [R16] rxd stuck fault sets flag and forces receive-only
// [R17] rxd output driver turned off at once on that fault
// [R18] driver held off, fault shown in status
// [R19] txd high recessive, low dominant; rxd follows bus state
// [R20] receive-only keeps driver off while rxd reports the bus
// [R21] driver re-enabled only after fault gone, flags read, tx mode chosen
// [R22] pattern count restarts when window expires
`timescale 1ns/1ps
`include "can_phy_diag_map.vh"
module can_phy_wake_and_fault_diag #(
    parameter DOM_CLAMP = `DOM_CLAMP_CYC,
    parameter RXD_CHECK_EN = 1
)(
    input wire clk,
    input wire rst,
    input wire txd,
    input wire rxd_pin_level,
    input wire diff_rx,
    input wire wake_rx,
    input wire low_line_ground_cmp,
    input wire high_line_ground_cmp,
    input wire low_line_battery_cmp,
    input wire high_line_battery_cmp,
    input wire low_line_five_volt_cmp,
    input wire high_line_five_volt_cmp,
    input wire [1:0] mode_req,
    input wire mode_req_strobe,
    input wire wake_enable,
    input wire single_pulse_wake_select,
    input wire device_low_power,
    input wire flags_read,
    output reg rxd,
    output reg rxd_oe,
    output reg drv_dominant,
    output reg drv_enable,
    output reg bias_enable,
    output reg term_to_ground,
    output reg split_enable,
    output reg wake_flag,
    output reg int_pulse,
    output reg device_wake,
    output reg [2:0] bus_fault,
    output reg bus_fault_valid,
    output reg clamp_flag,
    output reg rxd_high_flag,
    output reg [1:0] mode
);
    // pins and analog comparators are asynchronous, two stages each
    reg [10:0] sync1;
    reg [10:0] sync2;
    wire [10:0] raw = {txd, rxd_pin_level, diff_rx, wake_rx, low_line_ground_cmp,
        high_line_ground_cmp, low_line_battery_cmp, high_line_battery_cmp,
        low_line_five_volt_cmp, high_line_five_volt_cmp, 1'b0};
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync1 <= 11'h000;
            sync2 <= 11'h000;
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end
    wire s_txd = sync2[10];
    wire s_rxd_pin = sync2[9];
    wire s_diff = sync2[8];
    wire s_wake = sync2[7];
    wire s_lg = sync2[6];
    wire s_hg = sync2[5];
    wire s_lb = sync2[4];
    wire s_hb = sync2[3];
    wire s_l5 = sync2[2];
    wire s_h5 = sync2[1];

    // wake detector only runs in sleep with enable set
    wire wake_active = (mode == `MODE_SLEEP) && wake_enable; // [R4]
    wire wake_hit;
    can_wake_detect u_wake (
        .clk(clk),
        .rst(rst),
        .active(wake_active),
        .single_pulse_wake_select(single_pulse_wake_select),
        .wake_rx_dominant(s_wake),
        .wake(wake_hit)
    );

    // recessive-state classification: only tells ground, battery or five volt, not the line
    reg [2:0] rec_class;
    reg [2:0] dom_class;
    reg [2:0] rec_latched;
    always @*
    begin
        rec_class = `FAULT_NONE;
        if (!s_lg && !s_hg)
            rec_class = `FAULT_LOW_GND; // [R9] [R12]
        else if (s_lb && s_hb)
            rec_class = `FAULT_LOW_BAT; // [R10] [R12]
        else if (s_l5 && s_h5)
            rec_class = `FAULT_LOW_5V; // [R11]
    end
    // dominant sample, read against the latched recessive class, resolves the line
    always @*
    begin
        dom_class = `FAULT_UNKNOWN;
        case (rec_latched)
            `FAULT_NONE:
                dom_class = (!s_lg && s_hg && !s_lb && !s_hb && !s_l5 && !s_h5)
                    ? `FAULT_NONE : `FAULT_UNKNOWN;
            `FAULT_LOW_GND:
                dom_class = (!s_lg && s_hg) ? `FAULT_LOW_GND :
                    (!s_lg && !s_hg) ? `FAULT_HIGH_GND : `FAULT_UNKNOWN; // [R9]
            `FAULT_LOW_BAT:
                dom_class = (s_lb && s_hb) ? `FAULT_LOW_BAT :
                    (!s_lb && s_hb) ? `FAULT_HIGH_BAT : `FAULT_UNKNOWN; // [R10]
            `FAULT_LOW_5V:
                dom_class = (s_l5 && s_h5) ? `FAULT_LOW_5V :
                    (!s_l5 && s_h5) ? `FAULT_HIGH_5V : `FAULT_UNKNOWN; // [R11]
            default:
                dom_class = `FAULT_UNKNOWN;
        endcase
    end

    // classify as the dominant phase ends: comparators lag txd by a few cycles,
    // so only then do they show the dominant readings
    reg prev_dom;
    reg [2:0] last_class;
    reg [2:0] same_cnt;
    wire driving = drv_enable;
    wire dom_now = driving && !s_txd;
    wire enter_dom = prev_dom && !dom_now;
    wire [2:0] cyc_class = dom_class;

    // dominant clamp counter and rxd check
    reg [31:0] clamp_cnt;
    reg prev_diff;
    // receiver output goes back to recessive; a sound rxd pin still lags low here
    wire diff_rise = !s_diff && prev_diff;
    wire rxd_fault_now = (RXD_CHECK_EN != 0) && diff_rise && s_rxd_pin; // [R15]
    wire fault_present = rxd_high_flag || clamp_flag ||
        (bus_fault_valid && bus_fault != `FAULT_NONE);
    reg faults_read;

    always @(posedge clk)
    begin
        if (rst)
        begin
            prev_dom <= 1'b0;
            rec_latched <= `FAULT_NONE;
            last_class <= `FAULT_NONE;
            same_cnt <= 3'h0;
            bus_fault <= `FAULT_NONE;
            bus_fault_valid <= 1'b0;
            clamp_cnt <= 32'h00000000;
            clamp_flag <= 1'b0;
            prev_diff <= 1'b0;
            rxd_high_flag <= 1'b0;
            wake_flag <= 1'b0;
            int_pulse <= 1'b0;
            device_wake <= 1'b0;
            faults_read <= 1'b0;
            mode <= `MODE_TXRX;
        end
        else
        begin
            prev_dom <= dom_now;
            prev_diff <= s_diff;
            int_pulse <= 1'b0;
            device_wake <= 1'b0;
            if (driving && s_txd)
                rec_latched <= rec_class;
            if (enter_dom)
            begin
                last_class <= cyc_class;
                if (cyc_class == last_class)
                begin
                    if (same_cnt != 3'd`FAULT_CONFIRM_CYCLES)
                        same_cnt <= same_cnt + 3'h1;
                    if (same_cnt >= 3'd`FAULT_CONFIRM_CYCLES - 3'd1 &&
                        cyc_class != `FAULT_UNKNOWN && cyc_class != `FAULT_NONE)
                    begin
                        bus_fault <= cyc_class; // [R13]
                        bus_fault_valid <= 1'b1;
                    end
                end
                else
                    same_cnt <= 3'h1;
            end
            // bus dominant counts toward the clamp, whether or not this driver is transmitting
            if (!s_diff)
            begin
                clamp_cnt <= 32'h00000000;
            end
            else if (clamp_cnt < DOM_CLAMP)
                clamp_cnt <= clamp_cnt + 32'h00000001;
            // flags: a set in the same cycle beats a read clear
            if (flags_read)
            begin
                wake_flag <= 1'b0;
                faults_read <= 1'b1;
                if (!s_diff)
                    clamp_flag <= 1'b0;
                if (!diff_rise)
                    rxd_high_flag <= 1'b0;
            end
            if (s_diff && clamp_cnt >= DOM_CLAMP - 1)
                clamp_flag <= 1'b1; // [R14]
            if (rxd_fault_now)
            begin
                rxd_high_flag <= 1'b1; // [R16] [R18]
                faults_read <= 1'b0;
            end
            if (wake_hit)
            begin
                wake_flag <= 1'b1; // [R2]
                int_pulse <= 1'b1;
                device_wake <= device_low_power;
            end
            // mode control
            if (rxd_fault_now)
                mode <= `MODE_RXONLY; // [R16]
            else if (wake_hit)
                mode <= `MODE_TXRX; // [R3]
            else if (mode_req_strobe)
            begin
                if (mode_req == `MODE_TXRX)
                begin
                    if (!fault_present && faults_read)
                        mode <= `MODE_TXRX; // [R21]
                    else if (!fault_present && !rxd_high_flag)
                        mode <= `MODE_TXRX;
                end
                else if (mode_req == `MODE_SLEEP || mode_req == `MODE_RXONLY)
                    mode <= mode_req;
            end
        end
    end

    // pin side outputs, all registered
    always @(posedge clk)
    begin
        if (rst)
        begin
            rxd <= 1'b1;
            rxd_oe <= 1'b1;
            drv_dominant <= 1'b0;
            drv_enable <= 1'b0;
            bias_enable <= 1'b1;
            term_to_ground <= 1'b0;
            split_enable <= 1'b1;
        end
        else
        begin
            rxd <= !s_diff; // [R19]
            rxd_oe <= !(rxd_high_flag || rxd_fault_now); // [R17]
            // driver only enabled with txd recessive, then follows txd
            if (mode != `MODE_TXRX || rxd_high_flag || rxd_fault_now)
                drv_enable <= 1'b0; // [R18] [R20]
            else if (s_txd)
                drv_enable <= 1'b1;
            drv_dominant <= (mode == `MODE_TXRX) && !rxd_high_flag && !rxd_fault_now
                && drv_enable && !s_txd; // [R19]
            bias_enable <= (mode != `MODE_SLEEP); // [R3]
            term_to_ground <= (mode == `MODE_SLEEP); // [R1]
            split_enable <= (mode != `MODE_SLEEP); // [R1]
        end
    end
endmodule

// ===== core/can_wake_detect.v
// pattern and single pulse can bus wake-up detector
`timescale 1ns/1ps
`include "can_phy_diag_map.vh"
module can_wake_detect #(
    parameter PULSE_MIN = `WAKE_PULSE_MIN_CYC,
    parameter SINGLE_MIN = `WAKE_SINGLE_CYC,
    parameter WINDOW = `WAKE_WINDOW_CYC
)(
    input wire clk,
    input wire rst,
    input wire active,
    input wire single_pulse_wake_select,
    input wire wake_rx_dominant,
    output reg wake
);
    reg [15:0] pulse_cnt;
    reg [15:0] win_cnt;
    reg [1:0] valid_cnt;
    reg counted;
    wire [15:0] need = single_pulse_wake_select ? SINGLE_MIN[15:0] : PULSE_MIN[15:0];
    always @(posedge clk)
    begin
        if (rst || !active)
        begin
            pulse_cnt <= 16'h0000;
            win_cnt <= 16'h0000;
            valid_cnt <= 2'h0;
            counted <= 1'b0;
            wake <= 1'b0;
        end
        else
        begin
            wake <= 1'b0;
            if (wake_rx_dominant)
            begin
                if (pulse_cnt != 16'hffff)
                    pulse_cnt <= pulse_cnt + 16'h0001;
            end
            else
            begin
                pulse_cnt <= 16'h0000;
                counted <= 1'b0;
            end
            if (valid_cnt != 2'h0)
                win_cnt <= win_cnt + 16'h0001;
            if (valid_cnt != 2'h0 && win_cnt >= WINDOW[15:0] - 16'h0001)
            begin
                valid_cnt <= 2'h0; // [R8] [R22]
                win_cnt <= 16'h0000;
            end
            else if (wake_rx_dominant && !counted && pulse_cnt + 16'h0001 >= need)
            begin
                counted <= 1'b1; // [R7]
                if (single_pulse_wake_select)
                    wake <= 1'b1; // [R6]
                else if (valid_cnt == 2'd`WAKE_PATTERN_PULSES - 2'd1)
                begin
                    wake <= 1'b1; // [R5]
                    valid_cnt <= 2'h0;
                    win_cnt <= 16'h0000;
                end
                else
                    valid_cnt <= valid_cnt + 2'h1;
            end
        end
    end
endmodule
